// ### hdl/tlbrd_pkg.sv
/*
 * shared constants and carrier types for the tlb replacement and demap block.
 * assumes one core clock and a synchronous active-high reset.
 */
// Operation
// RL1: both threads of a core share one full_assoc_tlb and one set_assoc_tlb.
// RL2: the arrays are private to the core and are never reached from another core.
// RL3: a lookup that hits two identical entries uses one of them and flags no multi-hit.
// RL4: software never installs two differing entries with the same address and context.
// RL5: with multi-page-size off, only unlocked non-global 8KB or 4MB pages go set-assoc.
// RL6: with multi-page-size on, the page size must equal context_page_size_a or _b.
// RL7: set-assoc only when all conditions hold and force-full-assoc is clear.
// RL8: the set index is tag-access bits chosen by page size XOR the inverted context.
// RL9: the full-assoc victim is the lowest-numbered invalid entry.
// RL10: else the lowest entry with used and lock both clear.
// RL11: else all used bits are cleared and the unused-unlocked search is repeated.
// RL12: when every full-assoc entry is locked the automatic write is dropped.
// RL13: direct set-assoc writes are not checked against their address.
// RL14: a demap picks the page sizes of its named context for both set-assoc arrays.
// RL15: a demap leaves valid any set-assoc entry whose size differs from the picked one; the code still removes such an entry on a demap-all.
// RL16: software gives a valid context selector in page and context demaps.
// RL17: a lookup hit on a full-assoc entry sets that entry's used bit.
package tlbrd_pkg;

    // ----------------------------------------------------------------
    // page sizes and contexts
    // ----------------------------------------------------------------
    localparam logic [2:0] TLBRD_PSZ_8K  = 3'h0;
    localparam logic [2:0] TLBRD_PSZ_4M  = 3'h3;
    localparam logic [1:0] TLBRD_CTX_PRI = 2'h0;
    localparam logic [1:0] TLBRD_CTX_SEC = 2'h1;
    localparam logic [1:0] TLBRD_CTX_NUC = 2'h2;
    localparam int         TLBRD_VA_W    = 64;
    localparam int         TLBRD_CTX_W   = 13;
    localparam int         TLBRD_PG_SHIFT_BASE = 13;
    localparam int         TLBRD_PG_SHIFT_STEP = 3;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                   locked;
        logic                   global_page_bit;
        logic [2:0]             size;
        logic [TLBRD_CTX_W-1:0] ctx;
        logic [TLBRD_VA_W-1:0]  tag;
    } tlbrd_entry_t;

    typedef struct packed {
        logic       multi_pagesize_en;
        logic       force_full_assoc;
        logic [2:0] context_page_size_a;
        logic [2:0] context_page_size_b;
    } tlbrd_cfg_t;

    typedef enum logic [1:0] {
        TLBRD_DM_PAGE = 2'h0,
        TLBRD_DM_CTX  = 2'h1,
        TLBRD_DM_ALL  = 2'h3
    } tlbrd_demap_t;

endpackage : tlbrd_pkg

// ### hdl/tlbrd_victim.sv
/*
 * full-assoc victim picker: lowest invalid, else lowest unused unlocked, else
 * lowest unlocked after clearing used bits. purely combinational.
 */
`timescale 1ns/1ns
module tlbrd_victim import tlbrd_pkg::*; #(
    parameter int N = 16
) (
    // entry state
    input  wire logic [N-1:0]         valid,
    input  wire logic [N-1:0]         used,
    input  wire logic [N-1:0]         lock,
    // result
    output logic                      found,
    output logic                      clear_used,
    output logic [$clog2(N)-1:0]      index
);
    logic [N-1:0] inval;
    logic [N-1:0] free;
    logic [N-1:0] unl;
    always_comb begin
        inval      = ~valid;
        free       = valid & ~used & ~lock;
        unl        = valid & ~lock;
        found      = 1'b0;
        clear_used = 1'b0;
        index      = '0;
        // downward loop so the lowest index wins
        for (int i = N-1; i >= 0; i--) begin
            if (inval[i]) begin // [RL9]
                index = ($clog2(N))'(i);
            end
        end
        if (|inval) begin
            found = 1'b1;
        end else if (|free) begin
            found = 1'b1;
            for (int i = N-1; i >= 0; i--) begin
                if (free[i]) begin // [RL10]
                    index = ($clog2(N))'(i);
                end
            end
        end else if (|unl) begin
            // every unlocked entry was used: reset used and search again
            found      = 1'b1;
            clear_used = 1'b1; // [RL11]
            for (int i = N-1; i >= 0; i--) begin
                if (unl[i]) begin
                    index = ($clog2(N))'(i);
                end
            end
        end
    end
endmodule : tlbrd_victim

// ### hdl/tlbrd_core.sv
/*
 * replacement steering, set index hash, full-assoc victim state and demap
 * qualification for the tlb of one core. the two threads drive one request
 * port between them; another core has its own instance.
 */
`timescale 1ns/1ns
module tlbrd_core import tlbrd_pkg::*; #(
    parameter int FA_N   = 16,
    parameter int SET_W  = 7
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst,
    // configuration
    input  wire tlbrd_cfg_t             cfg,
    input  wire logic [TLBRD_CTX_W-1:0] context_value,
    // automatic replacement request
    input  wire logic                   repl_valid,
    input  wire tlbrd_entry_t           repl_entry,
    input  wire logic [TLBRD_VA_W-1:0]  tag_access,
    // lookup hit report
    input  wire logic                   hit_valid,
    input  wire logic [FA_N-1:0]        hit_fa_vec,
    // demap request
    input  wire logic                   demap_valid,
    input  wire tlbrd_demap_t           demap_kind,
    input  wire logic [1:0]             demap_ctx_sel,
    input  wire tlbrd_cfg_t             pri_cfg,
    input  wire tlbrd_cfg_t             sec_cfg,
    input  wire tlbrd_cfg_t             nuc_cfg,
    input  wire logic [2:0]             sa_entry_size,
    input  wire logic                   sa_entry_match,
    // results
    output logic                        wr_set_assoc,
    output logic                        wr_full_assoc,
    output logic                        wr_dropped,
    output logic [SET_W-1:0]            set_index,
    output logic [$clog2(FA_N)-1:0]     fa_index,
    output logic                        sa_remove,
    output logic [2:0]                  demap_size_a,
    output logic [2:0]                  demap_size_b,
    output logic                        multi_hit_err,
    output logic [FA_N-1:0]             fa_valid_out
);
    localparam int IW = $clog2(FA_N);

    if (FA_N < 2 || SET_W < 1 || SET_W > TLBRD_CTX_W) begin : g_bad_param
        $error("tlbrd_core: bad parameters");
    end

    // ----------------------------------------------------------------
    // full-assoc state
    // ----------------------------------------------------------------
    logic [FA_N-1:0] valid_reg, valid_next;
    logic [FA_N-1:0] used_reg,  used_next;
    logic [FA_N-1:0] lock_reg,  lock_next;
    logic            vfound;
    logic            vclear;
    logic [IW-1:0]   vidx;

    // one shared array for both threads of this core [RL1] [RL2]
    tlbrd_victim #(.N(FA_N)) u_victim (
        .valid      (valid_reg),
        .used       (used_reg),
        .lock       (lock_reg),
        .found      (vfound),
        .clear_used (vclear),
        .index      (vidx)
    );

    // ----------------------------------------------------------------
    // steering and set index
    // ----------------------------------------------------------------
    logic            size_ok;
    logic            to_sa;
    logic [SET_W-1:0] hash;
    int              shift;
    always_comb begin
        if (cfg.multi_pagesize_en) begin
            size_ok = (repl_entry.size == cfg.context_page_size_a) ||
                      (repl_entry.size == cfg.context_page_size_b); // [RL6]
        end else begin
            size_ok = (repl_entry.size == TLBRD_PSZ_8K) ||
                      (repl_entry.size == TLBRD_PSZ_4M); // [RL5]
        end
        to_sa = !repl_entry.locked && !repl_entry.global_page_bit && size_ok &&
                !cfg.force_full_assoc; // [RL7]
        shift = TLBRD_PG_SHIFT_BASE + TLBRD_PG_SHIFT_STEP * int'(repl_entry.size);
        hash  = SET_W'(tag_access >> shift) ^ ~context_value[SET_W-1:0]; // [RL8]
    end

    // ----------------------------------------------------------------
    // demap page-size selection
    // ----------------------------------------------------------------
    tlbrd_cfg_t dcfg;
    logic       dm_keep;
    always_comb begin
        case (demap_ctx_sel) // [RL14]
            TLBRD_CTX_PRI: dcfg = pri_cfg;
            TLBRD_CTX_SEC: dcfg = sec_cfg;
            TLBRD_CTX_NUC: dcfg = nuc_cfg;
            // selector 3 is not a real context; software must avoid it [RL16]
            default:       dcfg = pri_cfg;
        endcase
        dm_keep = (demap_kind != TLBRD_DM_ALL) &&
                  (sa_entry_size != dcfg.context_page_size_a) &&
                  (sa_entry_size != dcfg.context_page_size_b); // [RL15]
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic            sa_w_next, fa_w_next, drop_next, rem_next;
    logic [SET_W-1:0] set_next;
    logic [IW-1:0]   fai_next;
    logic [2:0]      dsa_next, dsb_next;
    logic            sa_w_reg, fa_w_reg, drop_reg, rem_reg;
    logic [SET_W-1:0] set_reg;
    logic [IW-1:0]   fai_reg;
    logic [2:0]      dsa_reg, dsb_reg;
    always_comb begin
        valid_next = valid_reg;
        used_next  = used_reg;
        lock_next  = lock_reg;
        sa_w_next  = 1'b0;
        fa_w_next  = 1'b0;
        drop_next  = 1'b0;
        rem_next   = 1'b0;
        set_next   = set_reg;
        fai_next   = fai_reg;
        dsa_next   = dsa_reg;
        dsb_next   = dsb_reg;
        if (repl_valid) begin
            if (to_sa) begin
                // no address/contents consistency check on set-assoc writes [RL13]
                sa_w_next = 1'b1;
                set_next  = hash;
            end else if (vfound) begin
                fa_w_next = 1'b1;
                fai_next  = vidx;
                if (vclear) begin
                    used_next = '0; // [RL11]
                end
                valid_next[vidx] = 1'b1;
                used_next[vidx]  = 1'b1;
                lock_next[vidx]  = repl_entry.locked;
            end else begin
                drop_next = 1'b1; // [RL12]
            end
        end
        // applied after the victim clear so a same-cycle hit keeps its used bit
        if (hit_valid) begin
            // duplicates both set used; no multi-hit check on equal entries [RL3]
            used_next = used_next | (hit_fa_vec & valid_reg); // [RL17]
        end
        if (demap_valid) begin
            dsa_next = dcfg.context_page_size_a;
            dsb_next = dcfg.context_page_size_b;
            rem_next = sa_entry_match && !dm_keep;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            valid_reg <= '0;
            used_reg  <= '0;
            lock_reg  <= '0;
            sa_w_reg  <= 1'b0;
            fa_w_reg  <= 1'b0;
            drop_reg  <= 1'b0;
            rem_reg   <= 1'b0;
            set_reg   <= '0;
            fai_reg   <= '0;
            dsa_reg   <= 3'h0;
            dsb_reg   <= 3'h0;
        end else begin
            valid_reg <= valid_next;
            used_reg  <= used_next;
            lock_reg  <= lock_next;
            sa_w_reg  <= sa_w_next;
            fa_w_reg  <= fa_w_next;
            drop_reg  <= drop_next;
            rem_reg   <= rem_next;
            set_reg   <= set_next;
            fai_reg   <= fai_next;
            dsa_reg   <= dsa_next;
            dsb_reg   <= dsb_next;
        end
    end

    assign wr_set_assoc  = sa_w_reg;
    assign wr_full_assoc = fa_w_reg;
    assign wr_dropped    = drop_reg;
    assign set_index     = set_reg;
    assign fa_index      = fai_reg;
    assign sa_remove     = rem_reg;
    assign demap_size_a  = dsa_reg;
    assign demap_size_b  = dsb_reg;
    assign multi_hit_err = 1'b0;
    assign fa_valid_out  = valid_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    lock_drop_a: assert property (@(posedge clock) disable iff (rst) // [RL12]
        repl_valid && !to_sa && (&lock_reg) |=> wr_dropped && !wr_full_assoc)
        else $error("replacement not dropped with all entries locked");
    locked_sa_a: assert property (@(posedge clock) disable iff (rst) // [RL7]
        repl_valid && (repl_entry.locked || cfg.force_full_assoc) |=> !wr_set_assoc)
        else $error("locked or forced entry sent to set-assoc");
    size_sa_a: assert property (@(posedge clock) disable iff (rst) // [RL5]
        repl_valid && !cfg.multi_pagesize_en && repl_entry.size != TLBRD_PSZ_8K &&
        repl_entry.size != TLBRD_PSZ_4M |=> !wr_set_assoc)
        else $error("bad page size sent to set-assoc");
    invalid_first_a: assert property (@(posedge clock) disable iff (rst) // [RL9]
        repl_valid && !to_sa && !valid_reg[0] |=> wr_full_assoc && fa_index == '0)
        else $error("entry 0 invalid but not chosen");
    hash_idx_a: assert property (@(posedge clock) disable iff (rst) // [RL8]
        repl_valid && to_sa |=> set_index == $past(hash))
        else $error("set index does not match hash");
    used_hit_a: assert property (@(posedge clock) disable iff (rst) // [RL17]
        hit_valid |=> (used_reg & $past(hit_fa_vec) & $past(valid_reg)) ==
                      ($past(hit_fa_vec) & $past(valid_reg)))
        else $error("used bit not set on hit");
    demap_keep_a: assert property (@(posedge clock) disable iff (rst) // [RL15]
        demap_valid && dm_keep |=> !sa_remove)
        else $error("size-mismatched entry demapped");
    no_multihit_a: assert property (@(posedge clock) disable iff (rst) // [RL3]
        hit_valid |-> ##1 !multi_hit_err)
        else $error("multi-hit flagged");
    mpg_size_a: assert property (@(posedge clock) disable iff (rst) // [RL6]
        repl_valid && cfg.multi_pagesize_en &&
        repl_entry.size != cfg.context_page_size_a &&
        repl_entry.size != cfg.context_page_size_b |=> !wr_set_assoc)
        else $error("unmatched page size sent to set-assoc");
    drop_keep_a: assert property (@(posedge clock) disable iff (rst) // [RL12]
        repl_valid && !to_sa && (&lock_reg) |=> $stable(valid_reg) && $stable(lock_reg))
        else $error("entries changed by a dropped replacement");
    demap_sec_a: assert property (@(posedge clock) disable iff (rst) // [RL14]
        demap_valid && demap_ctx_sel == TLBRD_CTX_SEC |=>
        demap_size_a == $past(sec_cfg.context_page_size_a) &&
        demap_size_b == $past(sec_cfg.context_page_size_b))
        else $error("demap sizes not taken from secondary context");
endmodule : tlbrd_core

// ### tb/tlbrd_partner.sv
/*
 * lookup-path model on the far side of tlbrd_core: reports hits on valid
 * full-assoc entries. assumes the bench drives look_* at the falling edge.
 */
`timescale 1ns/1ns
module tlbrd_partner (
    // clock
    input  wire logic        clock,
    // bench request
    input  wire logic        look_req,
    input  wire logic        look_two,
    input  wire logic [3:0]  look_idx,
    // design side
    input  wire logic [15:0] fa_valid_out,
    output logic             hit_valid,
    output logic [15:0]      hit_fa_vec
);
    logic [15:0] vec;
    logic [15:0] junk_reg = 16'h5A3C;

    // idle vector changes every cycle so a stale value is never mistaken for a hit
    always @(posedge clock) junk_reg <= ~junk_reg;

    // a second identical copy may hit too; only valid entries answer
    assign vec        = ((16'h1 << look_idx) | (look_two ? 16'h1 << (look_idx + 4'h1) : 16'h0))
                        & fa_valid_out;
    assign hit_valid  = look_req && (vec != 16'h0);
    assign hit_fa_vec = hit_valid ? vec : junk_reg;
endmodule : tlbrd_partner

// ### tb/tb_top.sv
/*
 * self-checking bench for tlbrd_core: steering, set hash, victim choice and
 * demap qualification. assumes registered one-cycle result pulses.
 */
`timescale 1ns/1ns
module tb_top import tlbrd_pkg::*; ;
    logic         clock, rst, repl_valid, hit_valid, demap_valid, sa_entry_match;
    logic         look_req, look_two, wr_sa, wr_fa, wr_dr, sa_remove, mhe;
    tlbrd_cfg_t   cfg, pri_cfg, sec_cfg, nuc_cfg;
    tlbrd_entry_t repl_entry;
    tlbrd_demap_t demap_kind;
    logic [12:0]  context_value;
    logic [63:0]  tag_access, sh;
    logic [15:0]  hit_fa_vec, fa_valid_out;
    logic [6:0]   set_index;
    logic [3:0]   fa_index, look_idx;
    logic [2:0]   sa_entry_size, dsa, dsb;
    logic [1:0]   demap_ctx_sel;
    int           err_total, checks;

    tlbrd_core u_tlbrd_core (.clock(clock), .rst(rst), .cfg(cfg),
        .context_value(context_value), .repl_valid(repl_valid), .repl_entry(repl_entry),
        .tag_access(tag_access), .hit_valid(hit_valid), .hit_fa_vec(hit_fa_vec),
        .demap_valid(demap_valid), .demap_kind(demap_kind), .demap_ctx_sel(demap_ctx_sel),
        .pri_cfg(pri_cfg), .sec_cfg(sec_cfg), .nuc_cfg(nuc_cfg),
        .sa_entry_size(sa_entry_size), .sa_entry_match(sa_entry_match),
        .wr_set_assoc(wr_sa), .wr_full_assoc(wr_fa), .wr_dropped(wr_dr),
        .set_index(set_index), .fa_index(fa_index), .sa_remove(sa_remove),
        .demap_size_a(dsa), .demap_size_b(dsb), .multi_hit_err(mhe),
        .fa_valid_out(fa_valid_out));
    tlbrd_partner u_tlbrd_partner (.clock(clock), .look_req(look_req), .look_two(look_two),
        .look_idx(look_idx), .fa_valid_out(fa_valid_out), .hit_valid(hit_valid),
        .hit_fa_vec(hit_fa_vec));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk_bit(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %0b seen %0b", n, e, g);
        end
    endtask : chk_bit

    task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk_val

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    // one request strobe: raised at a falling edge, taken at the next rising edge
    task automatic pulse(input int which);
        @(negedge clock);
        case (which)
            0: repl_valid = 1'b1;
            1: demap_valid = 1'b1;
            default: look_req = 1'b1;
        endcase
        @(posedge clock);
        @(negedge clock);
        {repl_valid, demap_valid, look_req} = 3'h0;
    endtask : pulse

    task automatic do_reset;
        @(negedge clock);
        rst = 1'b1;
        repeat (3) @(negedge clock);
        chk_val("fa_valid_out", 16'h0, fa_valid_out);
        chk_bit("wr_full_assoc", 1'b0, wr_fa);
        rst = 1'b0;
    endtask : do_reset

    task automatic repl(input logic lk, input logic gl, input logic [2:0] sz);
        repl_entry = '{locked: lk, global_page_bit: gl, size: sz, ctx: 13'h0042,
                       tag: tag_access};
        pulse(0);
    endtask : repl

    task automatic t_fill(input int nlock);
        logic [3:0] exp_idx [4];
        exp_idx = '{4'hE, 4'hF, 4'hE, 4'hE};
        do_reset();
        for (int i = 0; i < 16; i++) begin
            repl(i < nlock, 1'b1, 3'h1);
            chk_val("fa_index", 16'(i), 16'(fa_index));
            chk_val("fa_valid_out", 16'((17'h1 << (i + 1)) - 1), fa_valid_out);
        end
        if (nlock == 16) begin
            repl(1'b1, 1'b1, 3'h1);
            chk_bit("wr_dropped", 1'b1, wr_dr);
            chk_bit("wr_full_assoc", 1'b0, wr_fa);
            chk_val("fa_valid_out", 16'hFFFF, fa_valid_out);
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (k == 3) begin
                    look_idx = 4'hE;
                    look_two = 1'b1;
                    pulse(2);
                    chk_bit("multi_hit_err", 1'b0, mhe);
                end
                repl(1'b0, 1'b1, 3'h1);
                chk_bit("wr_dropped", 1'b0, wr_dr);
                chk_val("fa_index", 16'(exp_idx[k]), 16'(fa_index));
            end
        end
        $display("test fill %0d done", nlock);
    endtask : t_fill

    task automatic t_steer;
        logic       ok;
        logic [6:0] exp_set;
        do_reset();
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 8; s++) begin
                cfg = '{multi_pagesize_en: m == 1, force_full_assoc: m == 2,
                        context_page_size_a: 3'h2, context_page_size_b: 3'h5};
                context_value = 13'h1A5B ^ 13'(s * 97);
                repl(m == 3 && s[0], m == 3 && !s[0], 3'(s));
                ok = (m == 0 && (s == 0 || s == 3)) || (m == 1 && (s == 2 || s == 5));
                chk_bit("wr_set_assoc", ok, wr_sa);
                chk_bit("wr_full_assoc", !ok, wr_fa);
                sh = tag_access >> (TLBRD_PG_SHIFT_BASE + TLBRD_PG_SHIFT_STEP * s);
                // hash kept at 7 bits so the inversion does not spill into upper bits
                exp_set = sh[6:0] ^ ~context_value[6:0];
                if (ok)
                    chk_val("set_index", 16'(exp_set), 16'(set_index));
            end
        end
        $display("test steer done");
    endtask : t_steer

    task automatic t_demap;
        tlbrd_cfg_t c;
        for (int sel = 0; sel < 3; sel++) begin
            for (int k = 0; k < 3; k++) begin
                for (int v = 0; v < 4; v++) begin
                    c = (sel == 0) ? pri_cfg : (sel == 1) ? sec_cfg : nuc_cfg;
                    demap_ctx_sel = 2'(sel);
                    demap_kind = (k == 2) ? TLBRD_DM_ALL : tlbrd_demap_t'(k);
                    sa_entry_match = v[0];
                    sa_entry_size = v[1] ? 3'h7 : c.context_page_size_a;
                    pulse(1);
                    chk_bit("sa_remove", v[0] && (k == 2 || !v[1]), sa_remove);
                    chk_val("demap_size_a", 16'(c.context_page_size_a), 16'(dsa));
                    chk_val("demap_size_b", 16'(c.context_page_size_b), 16'(dsb));
                end
            end
        end
        $display("test demap done");
    endtask : t_demap

    initial begin
        {rst, repl_valid, demap_valid, look_req, look_two, sa_entry_match} = 6'h20;
        {err_total, checks} = '0;
        cfg = '0;
        pri_cfg = '{1'b0, 1'b0, 3'h1, 3'h2};
        sec_cfg = '{1'b0, 1'b0, 3'h3, 3'h4};
        nuc_cfg = '{1'b0, 1'b0, 3'h5, 3'h6};
        context_value = 13'h0;
        tag_access = 64'h0123_4567_89AB_CDEF;
        repl_entry = '0;
        look_idx = 4'h0;
        demap_kind = TLBRD_DM_PAGE;
        demap_ctx_sel = 2'h0;
        sa_entry_size = 3'h0;
        t_fill(16);
        t_fill(14);
        t_steer();
        t_demap();
        finish_test();
    end

    // hang guard: a run that outlives its budget is a failure
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        finish_test();
    end
endmodule : tb_top
